//--- src/serial_dac_input_update_logic.sv
// top: serial capture on the link clock, word fifo, converter register and switch decode
// What this block does
// - frame starts when chip select falls; data sampled on each rising serial clock edge.
// - each frame carries fourteen bits, most significant bit first.
// - chip select rising after fourteen bits copies shift register into converter register.
// - serial clock and data ignored while chip select is high.
// - strobe falling low after chip select rose updates converter register.
// - strobe held low means update at the chip select rising edge.
// - more than fourteen bits keeps only the last fourteen received.
// - fewer than fourteen bits leaves old bits in unshifted positions.
// - converter register is zero at power-up until a word is transferred.
// - power-up does not clear the shift register.
// - top four code bits decode into fifteen segment switch controls.
// - low ten code bits drive ten ladder switches directly.
// - code is straight binary, output is reference times code over 16384.
// - zero power-on code gives zero volts unipolar, minus reference bipolar.
`timescale 1ns/100ps

// ----------------------------------------------------------------------------
// word fifo
// ----------------------------------------------------------------------------
module word_fifo #(
  parameter int unsigned WIDTH = 14,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  // one wrap bit above the index tells full from empty
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW:0]      wr_q, wr_d, rd_q, rd_d;
  logic             push, pop;

  // honest full and empty from pointers with a wrap bit
  assign out_valid = (wr_q != rd_q);
  assign in_ready  = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_q[AW-1:0]];

  // pointers step once per accepted push or pop
  always_comb
  begin
    wr_d = wr_q + (AW+1)'(push);
    rd_d = rd_q + (AW+1)'(pop);
  end

  // next storage contents; only the slot under the write pointer changes
  always_comb
  begin
    mem_d = mem_q;
    if (push)
      mem_d[wr_q[AW-1:0]] = in_data;
  end

  // storage has no reset; only pointers need a defined state
  always_ff @(posedge clk)
  begin
    mem_q <= mem_d;
  end

  // pointer registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end
endmodule : word_fifo

// ----------------------------------------------------------------------------
// top level
// ----------------------------------------------------------------------------
module serial_dac_input_update_logic
  import serial_dac_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                resetn,
  input  wire logic                serial_clk,
  input  wire logic                chip_select_n,
  input  wire logic                serial_data,
  input  wire logic                output_update_n,
  output logic                     frame_overrun,
  output logic      [SEG_N-1:0]    segment_switches,
  output logic      [LADDER_N-1:0] ladder_switches,
  output logic      [CODE_W-1:0]   converter_code
);
  // --------------------------------------------------------------------------
  // link domain: shift register clocked by the serial clock
  // --------------------------------------------------------------------------
  logic [CODE_W-1:0] shift_q, shift_d;
  logic              lk_tgl_q, lk_tgl_d;
  logic [CODE_W-1:0] lk_word_q, lk_word_d;

  // shift only inside a frame; old bits stay for short frames, long ones keep the tail
  always_comb
  begin
    shift_d = shift_q;
    if (!chip_select_n)
      shift_d = {shift_q[CODE_W-2:0], serial_data};
  end

  // no reset: contents undefined until loaded, as the part behaves at power-up
  always_ff @(posedge serial_clk)
  begin
    shift_q <= shift_d;
  end

  // chip select rising edge closes the frame; serial clock may be stopped then
  always_comb
  begin
    lk_word_d = shift_q;
    lk_tgl_d  = ~lk_tgl_q;
  end

  // chip select is the capture clock; reset puts the toggle at the sync's reset level
  always_ff @(posedge chip_select_n or negedge resetn)
  begin
    if (!resetn)
    begin
      lk_tgl_q  <= 1'b0;
      lk_word_q <= CODE_RST;
    end
    else
    begin
      lk_tgl_q  <= lk_tgl_d;
      lk_word_q <= lk_word_d;
    end
  end

  // --------------------------------------------------------------------------
  // crossing: frame-end toggle and strobe through two flops
  // --------------------------------------------------------------------------
  // bit 0 is the only flop that sees the unsynchronised level
  logic [2:0] tgl_sync_q, tgl_sync_d;
  logic [1:0] upd_sync_q, upd_sync_d;
  logic       frame_end;
  logic       strobe_low;

  // two-flop synchronisers, plus a third toggle flop for the edge detector
  always_comb
  begin
    tgl_sync_d = {tgl_sync_q[1:0], lk_tgl_q};
    upd_sync_d = {upd_sync_q[0], output_update_n};
  end

  // strobe syncs reset high (idle) so reset shows no false load request
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tgl_sync_q <= '0;
      upd_sync_q <= 2'b11;
    end
    else
    begin
      tgl_sync_q <= tgl_sync_d;
      upd_sync_q <= upd_sync_d;
    end
  end

  // one-cycle pulse per closed frame; strobe level as seen after the sync
  assign frame_end  = tgl_sync_q[2] ^ tgl_sync_q[1];
  assign strobe_low = (upd_sync_q[1] == UPD_ONLOAD);

  // word is stable in lk_word_q well before the toggle is seen two flops later;
  // a new frame cannot close sooner at the 25 MHz link limit
  frame_word_t fifo_in, fifo_out;
  logic        fifo_in_ready, fifo_out_valid, fifo_pop;
  assign fifo_in.code = lk_word_q;

  word_fifo #(
    .WIDTH (CODE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (sys_clk),
    .resetn    (resetn),
    .in_valid  (frame_end),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out)
  );

  // --------------------------------------------------------------------------
  // update control: converter register load
  // --------------------------------------------------------------------------
  // a queued word waits in the strobe state until the strobe is seen low
  upd_state_t        st_q, st_d;
  logic [CODE_W-1:0] code_q, code_d;
  logic              ovr_q, ovr_d;
  logic              strobe_prev_q, strobe_prev_d;
  logic              strobe_fall;

  // a held-low strobe counts as well as a fresh fall, so a tied-low strobe never stalls
  assign strobe_fall = strobe_low && !strobe_prev_q;

  // fifo drains only when the register may take the word, so a held strobe stalls it
  always_comb
  begin
    st_d          = st_q;
    code_d        = code_q;
    fifo_pop      = 1'b0;
    strobe_prev_d = strobe_low;
    ovr_d         = ovr_q | (frame_end & ~fifo_in_ready);
    case (st_q)
      UPD_IDLE:
      begin
        if (fifo_out_valid)
        begin
          if (strobe_low)
          begin
            code_d   = fifo_out.code;
            fifo_pop = 1'b1;
          end
          else
            st_d = UPD_WAIT_STROBE;
        end
      end
      UPD_WAIT_STROBE:
      begin
        if (strobe_fall || strobe_low)
        begin
          code_d   = fifo_out.code;
          fifo_pop = 1'b1;
          st_d     = UPD_IDLE;
        end
      end
      default:
        st_d = UPD_IDLE;
    endcase
  end

  // update state and the converter register
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q          <= UPD_IDLE;
      code_q        <= CODE_RST;
      ovr_q         <= 1'b0;
      strobe_prev_q <= 1'b0;
    end
    else
    begin
      st_q          <= st_d;
      code_q        <= code_d;
      ovr_q         <= ovr_d;
      strobe_prev_q <= strobe_prev_d;
    end
  end

  // --------------------------------------------------------------------------
  // switch decode: thermometer on the msbs, ladder straight from the lsbs
  // --------------------------------------------------------------------------
  switch_ctl_t sw_d, sw_q;
  logic [SEG_BITS-1:0] seg_code;
  assign seg_code = code_q[CODE_W-1 -: SEG_BITS];

  // segment k ties to reference when the msb code exceeds k; straight binary
  generate
    for (genvar k = 0; k < SEG_N; k++)
    begin : g_seg
      assign sw_d.segment_switches[k] = (seg_code > SEG_BITS'(k));
    end
  endgenerate
  assign sw_d.ladder_switches = code_q[LADDER_N-1:0];

  // switches are registered so they never glitch while the code settles
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      sw_q <= '0;
    else
      sw_q <= sw_d;
  end

  // outputs straight from flops
  assign segment_switches = sw_q.segment_switches;
  assign ladder_switches  = sw_q.ladder_switches;
  assign converter_code   = code_q;
  assign frame_overrun    = ovr_q;
endmodule : serial_dac_input_update_logic

//--- src/serial_dac_pkg.sv
// package: widths, decode sizes and shared types for the serial converter front end
package serial_dac_pkg;
  localparam int unsigned CODE_W      = 14;     // data word width
  localparam int unsigned SEG_BITS    = 4;      // msbs decoded into segments
  localparam int unsigned SEG_N       = 15;     // segment switch count
  localparam int unsigned LADDER_N    = 10;     // ladder switch count
  localparam int unsigned FULL_SCALE  = 16384;  // code divisor, 2**CODE_W
  localparam int unsigned FIFO_DEPTH  = 8;      // words between domains
  localparam logic [13:0] CODE_RST    = 14'h0000; // converter register at power-up
  localparam logic        UPD_ONLOAD  = 1'b0;   // strobe value meaning update now

  // a received frame handed across the domain boundary
  typedef struct packed {
    logic [CODE_W-1:0] code;
  } frame_word_t;

  // what the analog switches see
  typedef struct packed {
    logic [SEG_N-1:0]    segment_switches;
    logic [LADDER_N-1:0] ladder_switches;
  } switch_ctl_t;

  typedef enum logic [1:0] { UPD_IDLE, UPD_WAIT_STROBE } upd_state_t;
endpackage : serial_dac_pkg

//--- tb/serial_dac_asserts.sv
// checker: decode and update timing at the converter front end ports
`timescale 1ns/100ps
module serial_dac_asserts
  import serial_dac_pkg::*;
(
  input wire logic                sys_clk,
  input wire logic                resetn,
  input wire logic                serial_clk,
  input wire logic                chip_select_n,
  input wire logic                serial_data,
  input wire logic                output_update_n,
  input wire logic                frame_overrun,
  input wire logic [SEG_N-1:0]    segment_switches,
  input wire logic [LADDER_N-1:0] ladder_switches,
  input wire logic [CODE_W-1:0]   converter_code
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ---------------------------------------------------------------
  // switch decode follows the converter register one edge later
  // ---------------------------------------------------------------
  a_ladder_follow: assert property (ladder_switches == $past(converter_code[9:0]))
    else $error("ladder switches off code");
  a_segment_thermo: assert property (segment_switches ==
    15'((16'h1 << $past(converter_code[13:10])) - 16'h1))
    else $error("segment decode wrong");
  a_segment_moves: assert property ($changed(segment_switches)
    |-> $past(converter_code[13:10]) != $past(converter_code[13:10], 2))
    else $error("segments moved alone");
  // ---------------------------------------------------------------
  // update control; strobe passes two sync flops, so allow slack
  // ---------------------------------------------------------------
  a_reset_zero: assert property ($rose(resetn) |-> converter_code == CODE_RST)
    else $error("code not cleared");
  a_hold_strobe: assert property (output_update_n [*6] |=> $stable(converter_code))
    else $error("code moved with strobe high");
  a_load_cause: assert property ($changed(converter_code) |-> !$past(output_update_n, 2)
    || !$past(output_update_n, 3) || !$past(output_update_n, 4))
    else $error("code moved without strobe");
  a_overrun_sticky: assert property (frame_overrun |=> frame_overrun)
    else $error("overrun flag dropped");
  // a full queue means no pop one cycle before the loss, so the strobe was
  // high in the sample that fed the sync four edges back
  a_overrun_cause: assert property ($rose(frame_overrun)
    |-> $past(output_update_n, 4))
    else $error("overrun without deferral");
endmodule : serial_dac_asserts

bind serial_dac_input_update_logic serial_dac_asserts i_chk (.sys_clk, .resetn,
  .serial_clk, .chip_select_n, .serial_data, .output_update_n, .frame_overrun,
  .segment_switches, .ladder_switches, .converter_code);

//--- tb/serial_dac_input_update_logic_tb_top.sv
// testbench: automatic and deferred updates, odd frame lengths, queue overflow
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module serial_dac_input_update_logic_tb_top
  import serial_dac_pkg::*;
;
  logic                sys_clk = 1'b0;
  logic                resetn = 1'b0;
  logic                output_update_n = 1'b0;
  logic                serial_clk, chip_select_n, serial_data, frame_overrun;
  logic [SEG_N-1:0]    segment_switches;
  logic [LADDER_N-1:0] ladder_switches;
  logic [CODE_W-1:0]   converter_code, exp_sr, old;
  int                  failures = 0;
  int                  cmp_count = 0;
  always #2.5 sys_clk = ~sys_clk;
  serial_master_model i_master (.serial_clk, .chip_select_n, .serial_data);
  serial_dac_input_update_logic i_dut (.sys_clk, .resetn, .serial_clk, .chip_select_n,
    .serial_data, .output_update_n, .frame_overrun, .segment_switches,
    .ladder_switches, .converter_code);
  // ---------------------------------------------------------------
  // helpers; the expected shift register is tracked bit by bit
  // ---------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic xfer(input logic [31:0] w, input int n);
    i_master.send(w, n);
    for (int i = n - 1; i >= 0; i--)
      exp_sr = {exp_sr[CODE_W-2:0], w[i]};
  endtask : xfer
  task automatic check_out(input logic [CODE_W-1:0] e);
    for (int i = 0; i < 40 && converter_code !== e; i++)
      @(negedge sys_clk);
    repeat (2) @(negedge sys_clk);
    `CHK("code", e, converter_code)
    `CHK("ladder", e[9:0], ladder_switches)
    `CHK("segments", 15'((16'h1 << e[13:10]) - 16'h1), segment_switches)
  endtask : check_out
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_auto();
    `CHK("reset code", CODE_RST, converter_code)
    for (int k = 0; k < 16; k++)
    begin
      xfer({k[3:0], 10'h2b5 ^ 10'(k)}, 14);
      check_out(exp_sr);
    end
    xfer(32'h1abcd, 16);
    check_out(exp_sr);
    i_master.idle_clocks(32'h3a5c, 14);
    xfer(32'h2d, 6);
    check_out(exp_sr);
    xfer({12'h9ad, 2'b00}, 14);
    check_out(exp_sr);
    `CHK("overrun idle", 1'b0, frame_overrun)
    $display("test frames done");
  endtask : t_auto
  task automatic t_defer();
    output_update_n = 1'b1;
    old = exp_sr;
    xfer(32'h1234, 14);
    repeat (20) @(negedge sys_clk);
    `CHK("held code", old, converter_code)
    output_update_n = 1'b0;
    check_out(exp_sr);
    $display("test deferred update done");
  endtask : t_defer
  task automatic t_fill();
    output_update_n = 1'b1;
    for (int k = 1; k <= 9; k++)
    begin
      xfer(32'h0111 * k, 14);
      if (k == 8)
        old = exp_sr;
    end
    repeat (8) @(negedge sys_clk);
    `CHK("overrun", 1'b1, frame_overrun)
    output_update_n = 1'b0;
    check_out(old);
    $display("test queue overflow done");
  endtask : t_fill
  initial
  begin
    repeat (16) @(negedge sys_clk);
    resetn = 1'b1;
    t_auto();
    t_defer();
    t_fill();
    end_sim();
  end
  // watchdog well beyond the roughly 14 us that the frames take
  initial
  begin
    #200000;
    failures++;
    end_sim();
  end
endmodule : serial_dac_input_update_logic_tb_top

//--- tb/serial_master_model.sv
// partner: serial controller that frames words with chip select
`timescale 1ns/100ps
module serial_master_model (
  output logic serial_clk,
  output logic chip_select_n,
  output logic serial_data
);
  initial
  begin
    serial_clk = 1'b0;
    chip_select_n = 1'b1;
    serial_data = 1'b0;
  end
  // ---------------------------------------------------------------
  // send bursts the clock only inside frames; data inverts once released so
  // a stale bit never looks like a valid one
  // ---------------------------------------------------------------
  task automatic send(input logic [31:0] w, input int n);
    #3.3 chip_select_n = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      #7.5 serial_data = w[i];
      #7.5 serial_clk = 1'b1;
      #15 serial_clk = 1'b0; // 30 ns period; frames far outlast the sync delay
    end
    #15 chip_select_n = 1'b1;
    serial_data = ~serial_data;
    #30;
  endtask : send
  // clock burst with chip select high; the device must ignore it
  task automatic idle_clocks(input logic [31:0] w, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      #7.5 serial_data = w[i];
      #7.5 serial_clk = 1'b1;
      #15 serial_clk = 1'b0;
    end
    #30;
  endtask : idle_clocks
endmodule : serial_master_model
